// >>> pkg/tcm_glue_pkg.sv
// Purpose: Shared constants and types for the tightly coupled memory glue controller.
// Assumes: One 100 MHz clock, asynchronous active-low reset.
// Notes:   Register offsets are byte addresses on the plain register port.
`default_nettype none
package tcm_glue_pkg;
  localparam int ADDR_W    = 15;  // Word address width of the tight memory.
  localparam int BANK_BIT  = 14;  // Address bit that splits the two banks.
  localparam int DATA_W    = 32;
  localparam int LANES     = 4;
  localparam int REG_AW    = 4;
  localparam int CTL_W     = 4;
  localparam int STAT_W    = 5;
  // Register offsets.
  localparam logic [REG_AW-1:0] REG_CONTROL = 4'h0;
  localparam logic [REG_AW-1:0] REG_STATUS  = 4'h4;
  // Control field positions.
  localparam int CTL_SPEED_BIT = 0;  // 1: speed layout, 0: power layout.
  localparam int CTL_BIST_BIT  = 1;  // 1: hold the core in bus reset for memory test.
  localparam int CTL_BOOT_BIT  = 2;  // Drives the instruction memory boot pin.
  localparam int CTL_HIVEC_BIT = 3;  // Drives the high vectors pin.
  localparam logic [CTL_W-1:0] CONTROL_RESET = 4'h0;
  // Controller states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_DMA   = 3'b010,
    ST_FORCE = 3'b100
  } glue_state_type;
  // One memory request: select, direction, byte lanes and word address.
  typedef struct packed {
    logic              sel;
    logic              write;
    logic [LANES-1:0]  lanes;
    logic [ADDR_W-1:0] addr;
  } mem_req_type;
  localparam mem_req_type MEM_REQ_RESET = '0;
endpackage
`default_nettype wire

// >>> rtl/tcm_memory_glue.sv
// Purpose: Glue between a core data/instruction tight memory port, a DMA master and
//          two banks of byte-wide synchronous RAM, plus a pipelined sequential ROM front end.
// Assumes: All inputs synchronous to i_clk; RAM read data valid one cycle after its inputs.
// Notes:   Memory controls and the wait output are registered, one cycle behind their cause.
// Function
// - Data wait comes from nonsequential loopback or from the DMA stall.
// - After a DMA access the resumed core access gets a forced nonsequential wait.
// - Memory address and controls come from core, DMA, or the capture register.
// - DMA during a core request takes memory; core attributes are captured then.
// - Wait stays high for every cycle the DMA access is active.
// - After DMA the captured request drives memory; wait one more cycle, then drops.
// - DMA may start with no core request; wait still asserted by the stall.
// - Four byte RAMs share address and select; lane k takes bits 8k+7:8k.
// - Equal even banks share low address bits; registered upper bits pick read data.
// - Power layout: each bank select is chip select gated by bit 14.
// - Speed layout: write enable gated by bit 14; both banks share chip select.
// - ROM front end pipelines address and select and increments on active select.
// - On a nonsequential fetch the ROM address takes the registered fetch address.
// - One signal drives DMA select and DMA chip select and steers lane/data muxes.
// - For memory test the core is held in bus reset; test logic is not reset.
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tcm_memory_glue
  import tcm_glue_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_rst_b,
  // Register port.
  input  wire logic [REG_AW-1:0] i_reg_addr,
  input  wire logic [DATA_W-1:0] i_reg_wdata,
  input  wire logic              i_reg_write,
  input  wire logic              i_reg_read,
  output logic      [DATA_W-1:0] o_reg_rdata,
  // Core data tight memory port.
  input  wire logic [ADDR_W-1:0] i_data_tight_memory_word_address,
  input  wire logic              i_data_tight_memory_chip_select,
  input  wire logic              i_data_tight_memory_sequential,
  input  wire logic [LANES-1:0]  i_data_tight_memory_byte_lane_strobe,
  input  wire logic              i_data_tight_memory_write_not_read,
  input  wire logic [DATA_W-1:0] i_data_tight_memory_write_data,
  output logic                   o_data_tight_memory_wait,
  output logic      [DATA_W-1:0] o_data_tight_memory_read_data,
  output logic                   o_data_tight_memory_dma_select,
  output logic                   o_data_tight_memory_dma_chip_select,
  // DMA master.
  input  wire logic              i_dma_stall,
  input  wire logic [ADDR_W-1:0] i_dma_address,
  input  wire logic              i_dma_write,
  input  wire logic [LANES-1:0]  i_dma_lanes,
  input  wire logic [DATA_W-1:0] i_dma_write_data,
  // RAM banks.
  output logic      [ADDR_W-1:0] o_mem_address,
  output logic      [DATA_W-1:0] o_mem_write_data,
  output logic                   o_bank_low_select,
  output logic                   o_bank_high_select,
  output logic      [LANES-1:0]  o_bank_low_write_enable,
  output logic      [LANES-1:0]  o_bank_high_write_enable,
  input  wire logic [DATA_W-1:0] i_bank_low_read_data,
  input  wire logic [DATA_W-1:0] i_bank_high_read_data,
  // Instruction side and ROM front end.
  input  wire logic [ADDR_W-1:0] i_instruction_tight_memory_address,
  input  wire logic              i_instruction_tight_memory_chip_select,
  input  wire logic              i_instruction_tight_memory_sequential,
  output logic                   o_instruction_tight_memory_wait,
  output logic      [ADDR_W-1:0] o_rom_address,
  output logic                   o_rom_select,
  // Core straps and test hold.
  output logic                   o_instruction_tight_memory_boot_enable_pin,
  output logic                   o_high_vectors_pin,
  output logic                   o_core_bus_reset_b
);

  // Byte write enables of one bank: each lane strobe is qualified by the bank write.
  function automatic logic [LANES-1:0] lane_enables(input logic          wr,
                                                    input logic [LANES-1:0] lanes);
    lane_enables = wr ? lanes : 4'h0;
  endfunction

  glue_state_type    state_reg, state_next;
  mem_req_type       cap_reg, cap_next;
  logic              cap_valid_reg, cap_valid_next;
  logic              wait_reg, wait_next;
  logic              dma_sel_reg, dma_sel_next;
  mem_req_type       mem_reg, mem_next;
  logic [DATA_W-1:0] wdata_reg, wdata_next;
  logic              low_sel_reg, low_sel_next;
  logic              high_sel_reg, high_sel_next;
  logic [LANES-1:0]  low_we_reg, low_we_next;
  logic [LANES-1:0]  high_we_reg, high_we_next;
  logic              rd_bank_reg, rd_bank_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic              resume;
  logic              speed;
  logic [CTL_W-1:0]  ctl_reg, ctl_next;
  logic              core_rst_b_reg, core_rst_b_next;
  logic [DATA_W-1:0] reg_rdata_reg, reg_rdata_next;
  logic [ADDR_W-1:0] rom_addr_reg, rom_addr_next;
  logic              rom_sel_reg, rom_sel_next;
  logic              iwait_reg, iwait_next;

  assign speed  = ctl_reg[CTL_SPEED_BIT];
  // The postponed core request restarts in the cycle the DMA stall drops.
  assign resume = (state_reg == ST_DMA) && !i_dma_stall && cap_valid_reg;

  // Arbitration, capture, wait and memory steering for the data side.
  always_comb
  begin
    state_next     = state_reg;
    cap_next       = cap_reg;
    cap_valid_next = cap_valid_reg;
    mem_next       = '{sel: i_data_tight_memory_chip_select, write: i_data_tight_memory_write_not_read,
                       lanes: i_data_tight_memory_byte_lane_strobe, addr: i_data_tight_memory_word_address};
    wdata_next     = i_data_tight_memory_write_data;
    case (state_reg)
      ST_IDLE:
        if (i_dma_stall) state_next = ST_DMA;
      ST_DMA:
        if (!i_dma_stall) state_next = cap_valid_reg ? ST_FORCE : ST_IDLE;
      ST_FORCE:
        state_next = i_dma_stall ? ST_DMA : ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
    // A core request met by DMA is held until the DMA is done.
    if (i_dma_stall && i_data_tight_memory_chip_select && !cap_valid_reg)
    begin
      cap_next       = mem_next;
      cap_valid_next = 1'b1;
    end
    if (i_dma_stall)
    begin
      // DMA owns the memory and always raises the select with it.
      mem_next   = '{sel: 1'b1, write: i_dma_write, lanes: i_dma_lanes,
                     addr: i_dma_address};
      wdata_next = i_dma_write_data;
    end
    else if (resume)
    begin
      mem_next       = cap_reg;
      mem_next.sel   = 1'b1;
      cap_valid_next = 1'b0;
    end
    // Wait: DMA stall, forced nonsequential override, or nonsequential loopback.
    wait_next = i_dma_stall || resume
                || (i_data_tight_memory_chip_select && !i_data_tight_memory_sequential);
    dma_sel_next = i_dma_stall;
    // Bank decode for the request the memory sees next.
    low_sel_next  = mem_next.sel && (speed || !mem_next.addr[BANK_BIT]);
    high_sel_next = mem_next.sel && (speed || mem_next.addr[BANK_BIT]);
    low_we_next   = lane_enables(mem_next.write && (!speed || !mem_next.addr[BANK_BIT]),
                                 mem_next.lanes);
    high_we_next  = lane_enables(mem_next.write && (!speed || mem_next.addr[BANK_BIT]),
                                 mem_next.lanes);
    // Read data: the bank bit of the request the RAM just took picks the bank.
    rd_bank_next = mem_reg.addr[BANK_BIT];
    rdata_next   = rd_bank_reg ? i_bank_high_read_data : i_bank_low_read_data;
  end

  // Registers of the data side.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      state_reg     <= ST_IDLE;
      cap_reg       <= MEM_REQ_RESET;
      cap_valid_reg <= 1'b0;
      wait_reg      <= 1'b0;
      dma_sel_reg   <= 1'b0;
      mem_reg       <= MEM_REQ_RESET;
      wdata_reg     <= '0;
      low_sel_reg   <= 1'b0;
      high_sel_reg  <= 1'b0;
      low_we_reg    <= 4'h0;
      high_we_reg   <= 4'h0;
      rd_bank_reg   <= 1'b0;
      rdata_reg     <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      cap_reg       <= cap_next;
      cap_valid_reg <= cap_valid_next;
      wait_reg      <= wait_next;
      dma_sel_reg   <= dma_sel_next;
      mem_reg       <= mem_next;
      wdata_reg     <= wdata_next;
      low_sel_reg   <= low_sel_next;
      high_sel_reg  <= high_sel_next;
      low_we_reg    <= low_we_next;
      high_we_reg   <= high_we_next;
      rd_bank_reg   <= rd_bank_next;
      rdata_reg     <= rdata_next;
    end
  end

  // Register port, straps, test hold and the sequential ROM front end.
  always_comb
  begin
    ctl_next       = ctl_reg;
    reg_rdata_next = '0;
    if (i_reg_write && (i_reg_addr == REG_CONTROL))
      ctl_next = i_reg_wdata[CTL_W-1:0];
    if (i_reg_read && (i_reg_addr == REG_CONTROL))
      reg_rdata_next = {{(DATA_W-CTL_W){1'b0}}, ctl_reg};
    else if (i_reg_read && (i_reg_addr == REG_STATUS))
      reg_rdata_next = {{(DATA_W-STAT_W){1'b0}}, state_reg, cap_valid_reg, wait_reg};
    // Memory test keeps the core in bus reset so its own select stays low.
    core_rst_b_next = !ctl_next[CTL_BIST_BIT];
    // ROM select follows the fetch select one cycle later.
    rom_sel_next  = i_instruction_tight_memory_chip_select;
    rom_addr_next = rom_addr_reg;
    if (i_instruction_tight_memory_chip_select && !i_instruction_tight_memory_sequential)
      rom_addr_next = i_instruction_tight_memory_address;
    else if (rom_sel_reg)
      rom_addr_next = rom_addr_reg + 15'h0001;
    // Loopback wait for nonsequential fetches, relying on the held sequential flag.
    iwait_next = i_instruction_tight_memory_chip_select && !i_instruction_tight_memory_sequential;
  end

  // Registers of the control side.
  always_ff @(posedge i_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ctl_reg        <= CONTROL_RESET;
      reg_rdata_reg  <= '0;
      core_rst_b_reg <= 1'b0;
      rom_addr_reg   <= '0;
      rom_sel_reg    <= 1'b0;
      iwait_reg      <= 1'b0;
    end
    else
    begin
      ctl_reg        <= ctl_next;
      reg_rdata_reg  <= reg_rdata_next;
      core_rst_b_reg <= core_rst_b_next;
      rom_addr_reg   <= rom_addr_next;
      rom_sel_reg    <= rom_sel_next;
      iwait_reg      <= iwait_next;
    end
  end

  // Outputs, each straight from its flip-flop.
  assign o_reg_rdata              = reg_rdata_reg;
  assign o_data_tight_memory_wait              = wait_reg;
  assign o_data_tight_memory_read_data         = rdata_reg;
  assign o_data_tight_memory_dma_select        = dma_sel_reg;
  assign o_data_tight_memory_dma_chip_select   = dma_sel_reg;
  assign o_mem_address            = mem_reg.addr;
  assign o_mem_write_data         = wdata_reg;
  assign o_bank_low_select        = low_sel_reg;
  assign o_bank_high_select       = high_sel_reg;
  assign o_bank_low_write_enable  = low_we_reg;
  assign o_bank_high_write_enable = high_we_reg;
  assign o_instruction_tight_memory_wait              = iwait_reg;
  assign o_rom_address            = rom_addr_reg;
  assign o_rom_select             = rom_sel_reg;
  // The device samples these straps during its reset and then follows its region registers.
  assign o_instruction_tight_memory_boot_enable_pin   = ctl_reg[CTL_BOOT_BIT];
  assign o_high_vectors_pin       = ctl_reg[CTL_HIVEC_BIT];
  assign o_core_bus_reset_b       = core_rst_b_reg;

  // Checks on the glue behaviour.
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_b);

  property p_dma_wait;
    i_dma_stall |=> o_data_tight_memory_wait;
  endproperty
  a_dma_wait: assert property (p_dma_wait) else $error("wait low during DMA");

  property p_idle_dma;
    i_dma_stall && !i_data_tight_memory_chip_select |=> o_data_tight_memory_wait && o_mem_address == $past(i_dma_address);
  endproperty
  a_idle_dma: assert property (p_idle_dma) else $error("idle DMA not stalled");

  property p_dma_mem;
    i_dma_stall |=> (o_bank_low_select || o_bank_high_select) && o_data_tight_memory_dma_select;
  endproperty
  a_dma_mem: assert property (p_dma_mem) else $error("DMA not on memory");

  property p_capture;
    i_dma_stall && i_data_tight_memory_chip_select && !cap_valid_reg
      |=> cap_valid_reg && cap_reg.addr == $past(i_data_tight_memory_word_address);
  endproperty
  a_capture: assert property (p_capture) else $error("core request not captured");

  property p_resume;
    resume |=> o_data_tight_memory_wait && o_mem_address == $past(cap_reg.addr) && state_reg == ST_FORCE
      && !cap_valid_reg;
  endproperty
  a_resume: assert property (p_resume) else $error("captured request not resumed");

  property p_force_once;
    state_reg == ST_FORCE |-> $past(state_reg) == ST_DMA && !$past(i_dma_stall);
  endproperty
  a_force_once: assert property (p_force_once) else $error("override out of place");

  property p_loopback;
    i_data_tight_memory_chip_select && !i_data_tight_memory_sequential |=> o_data_tight_memory_wait;
  endproperty
  a_loopback: assert property (p_loopback) else $error("no nonsequential wait");

  property p_power_bank;
    !speed && $past(!speed) |-> !(o_bank_low_select && o_bank_high_select);
  endproperty
  a_power_bank: assert property (p_power_bank) else $error("both banks on");

  property p_speed_bank;
    speed && $past(speed) |-> o_bank_low_select == o_bank_high_select
      && !(|o_bank_low_write_enable && |o_bank_high_write_enable);
  endproperty
  a_speed_bank: assert property (p_speed_bank) else $error("speed bank decode");

  property p_rom_jump;
    i_instruction_tight_memory_chip_select && !i_instruction_tight_memory_sequential |=> o_rom_address == $past(i_instruction_tight_memory_address);
  endproperty
  a_rom_jump: assert property (p_rom_jump) else $error("ROM address not reloaded");

  property p_rom_step;
    rom_sel_reg && !(i_instruction_tight_memory_chip_select && !i_instruction_tight_memory_sequential)
      |=> o_rom_address == $past(rom_addr_reg) + 15'h0001;
  endproperty
  a_rom_step: assert property (p_rom_step) else $error("ROM address not stepped");

  c_dma_during_core: cover property (i_data_tight_memory_chip_select && i_dma_stall ##1 i_dma_stall ##1 resume);
  c_idle_dma:        cover property (!i_data_tight_memory_chip_select && i_dma_stall ##1 i_dma_stall);
  c_rom_run:         cover property (rom_sel_reg [*3]);

endmodule
`default_nettype wire

// >>> test/tcm_bank_model.sv
// Purpose: Behavioural model of one synchronous RAM bank built from four byte-wide RAMs.
// Assumes: Read data appear just after the clock edge at which the bank samples its select and address.
// Notes:   Only 1024 words are kept, so test addresses must differ in bits 9:0.
`timescale 1ns/1ps
`default_nettype none
module tcm_bank_model
  import tcm_glue_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic [ADDR_W-1:0] i_address,
  input  wire logic [DATA_W-1:0] i_write_data,
  input  wire logic              i_select,
  input  wire logic [LANES-1:0]  i_write_enable,
  output logic      [DATA_W-1:0] o_read_data
);
  logic [DATA_W-1:0] mem [0:1023];

  // Reads the old word, then writes each enabled byte lane from its own data bits.
  always @(posedge i_clk)
  begin
    if (i_select)
    begin
      o_read_data <= mem[i_address[9:0]];
      for (int k = 0; k < LANES; k++)
      begin
        if (i_write_enable[k])
        begin
          mem[i_address[9:0]][8*k +: 8] = i_write_data[8*k +: 8];
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/tcm_memory_glue_bench.sv
// Purpose: Self-checking bench for the tight memory glue controller.
// Assumes: Two bank models stand behind the glue; core, DMA and fetch ports are driven here.
// Notes:   Outputs are sampled at the falling edge after the edge that produced them.
`timescale 1ns/1ps
`default_nettype none
module tcm_memory_glue_bench
  import tcm_glue_pkg::*;
;
  logic              i_clk = 1'b0, i_rst_b = 1'b0, i_reg_write = 1'b0, i_reg_read = 1'b0;
  logic              i_data_tight_memory_chip_select = 1'b0, i_data_tight_memory_sequential = 1'b0;
  logic              i_data_tight_memory_write_not_read = 1'b0, i_dma_stall = 1'b0, i_dma_write = 1'b0;
  logic              i_instruction_tight_memory_chip_select = 1'b0, i_instruction_tight_memory_sequential = 1'b0;
  logic [REG_AW-1:0] i_reg_addr = '0;
  logic [DATA_W-1:0] i_reg_wdata = '0, i_data_tight_memory_write_data = '0, i_dma_write_data = '0;
  logic [ADDR_W-1:0] i_data_tight_memory_word_address = '0, i_dma_address = '0, i_instruction_tight_memory_address = '0;
  logic [LANES-1:0]  i_data_tight_memory_byte_lane_strobe = '0, i_dma_lanes = '0;
  logic [DATA_W-1:0] o_reg_rdata, o_data_tight_memory_read_data, o_mem_write_data, rd;
  logic [DATA_W-1:0] i_bank_low_read_data, i_bank_high_read_data;
  logic [ADDR_W-1:0] o_mem_address, o_rom_address;
  logic [LANES-1:0]  o_bank_low_write_enable, o_bank_high_write_enable;
  logic              o_data_tight_memory_wait, o_data_tight_memory_dma_select, o_data_tight_memory_dma_chip_select;
  logic              o_bank_low_select, o_bank_high_select, o_instruction_tight_memory_wait, o_rom_select;
  logic              o_instruction_tight_memory_boot_enable_pin, o_high_vectors_pin, o_core_bus_reset_b;
  int                err_count = 0;
  int                compares = 0;

  // Device under test, every port tied to the bench signal of the same name.
  tcm_memory_glue tcm_memory_glue_inst (.*);

  // Low and high RAM banks behind the glue.
  tcm_bank_model bank_low_inst (
    .i_clk          (i_clk),
    .i_address      (o_mem_address),
    .i_write_data   (o_mem_write_data),
    .i_select       (o_bank_low_select),
    .i_write_enable (o_bank_low_write_enable),
    .o_read_data    (i_bank_low_read_data)
  );
  tcm_bank_model bank_high_inst (
    .i_clk          (i_clk),
    .i_address      (o_mem_address),
    .i_write_data   (o_mem_write_data),
    .i_select       (o_bank_high_select),
    .i_write_enable (o_bank_high_write_enable),
    .o_read_data    (i_bank_high_read_data)
  );

  // Free-running 100 MHz clock.
  always #5 i_clk = ~i_clk;

  // Compares one value and counts it; a mismatch is reported at once.
  task automatic chk(input string name, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One-cycle register write strobe.
  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1'b1;
    @(posedge i_clk);
    i_reg_write <= 1'b0;
  endtask

  // One-cycle read strobe; data are taken in the following cycle only.
  task automatic reg_read(input logic [REG_AW-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_reg_addr <= a;
    i_reg_read <= 1'b1;
    @(posedge i_clk);
    i_reg_read <= 1'b0;
    @(negedge i_clk);
    d = o_reg_rdata;
  endtask

  // One nonsequential core request; returns just after the edge that sampled it.
  task automatic core_op(input logic [ADDR_W-1:0] a, input logic w,
                         input logic [LANES-1:0] l, input logic [DATA_W-1:0] d);
    @(posedge i_clk);
    i_data_tight_memory_chip_select <= 1'b1;
    i_data_tight_memory_sequential <= 1'b0;
    i_data_tight_memory_word_address <= a;
    i_data_tight_memory_write_not_read <= w;
    i_data_tight_memory_byte_lane_strobe <= l;
    i_data_tight_memory_write_data <= d;
    @(posedge i_clk);
    i_data_tight_memory_chip_select <= 1'b0;
    i_data_tight_memory_write_not_read <= 1'b0;
  endtask

  // Core read; data come two cycles after the memory controls.
  task automatic core_read(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    core_op(a, 1'b0, 4'h0, 32'h0);
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("read_data", o_data_tight_memory_read_data, exp);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Cuts a hang short; the tests need well under a thousand cycles.
  initial
  begin
    #50000;
    err_count++;
    test_done();
  end

  // Main test sequence.
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(negedge i_clk);
    chk("bus_reset_release", o_core_bus_reset_b, 32'h1);
    reg_read(REG_CONTROL, rd);
    chk("control_reset", rd, 32'h0);
    chk("boot_reset", o_instruction_tight_memory_boot_enable_pin, 32'h0);
    reg_read(REG_STATUS, rd);
    chk("status_reset", rd, 32'h4);
    reg_write(REG_CONTROL, 32'hffff_fffc);
    reg_write(REG_STATUS, 32'hffff_ffff);
    reg_read(REG_CONTROL, rd);
    chk("control_bits", rd, 32'hc);
    chk("boot_pin", o_instruction_tight_memory_boot_enable_pin, 32'h1);
    chk("high_vec_pin", o_high_vectors_pin, 32'h1);
    reg_write(REG_CONTROL, 32'h6);
    reg_read(4'h8, rd);
    chk("unmapped", rd, 32'h0);
    chk("boot_only", o_instruction_tight_memory_boot_enable_pin, 32'h1);
    chk("high_vec_off", o_high_vectors_pin, 32'h0);
    chk("bus_hold", o_core_bus_reset_b, 32'h0);
    reg_write(REG_CONTROL, 32'h0);
    $display("test registers done");
    core_op(15'h4005, 1'b1, 4'hf, 32'h1111_2222);
    @(negedge i_clk);
    chk("pw_addr", o_mem_address, 32'h4005);
    chk("pw_high_sel", o_bank_high_select, 32'h1);
    chk("pw_low_sel", o_bank_low_select, 32'h0);
    chk("pw_we", o_bank_high_write_enable, 32'hf);
    chk("pw_wdata", o_mem_write_data, 32'h1111_2222);
    chk("nonseq_wait", o_data_tight_memory_wait, 32'h1);
    core_op(15'h0005, 1'b1, 4'hf, 32'h3333_4444);
    core_op(15'h4005, 1'b1, 4'h2, 32'h0000_ab00);
    core_read(15'h4005, 32'h1111_ab22);
    core_read(15'h0005, 32'h3333_4444);
    reg_write(REG_CONTROL, 32'h1);
    core_op(15'h0006, 1'b1, 4'hf, 32'h5555_6666);
    @(negedge i_clk);
    chk("sp_low_sel", o_bank_low_select, 32'h1);
    chk("sp_high_sel", o_bank_high_select, 32'h1);
    chk("sp_high_we", o_bank_high_write_enable, 32'h0);
    chk("sp_low_we", o_bank_low_write_enable, 32'hf);
    core_read(15'h0006, 32'h5555_6666);
    reg_write(REG_CONTROL, 32'h0);
    $display("test banks done");
    // A core request postponed by a two-cycle DMA access.
    @(posedge i_clk);
    i_data_tight_memory_chip_select <= 1'b1;
    i_data_tight_memory_sequential <= 1'b1;
    i_data_tight_memory_word_address <= 15'h0100;
    i_dma_stall <= 1'b1;
    i_dma_address <= 15'h0200;
    @(posedge i_clk);
    i_data_tight_memory_chip_select <= 1'b0;
    @(negedge i_clk);
    chk("dma_addr", o_mem_address, 32'h0200);
    chk("dma_sel", o_data_tight_memory_dma_select, 32'h1);
    chk("dma_cs", o_data_tight_memory_dma_chip_select, 32'h1);
    chk("dma_wait1", o_data_tight_memory_wait, 32'h1);
    @(posedge i_clk);
    i_dma_stall <= 1'b0;
    @(negedge i_clk);
    chk("dma_wait2", o_data_tight_memory_wait, 32'h1);
    @(negedge i_clk);
    chk("resume_addr", o_mem_address, 32'h0100);
    chk("resume_sel", o_bank_low_select, 32'h1);
    chk("resume_wait", o_data_tight_memory_wait, 32'h1);
    chk("resume_dma_sel", o_data_tight_memory_dma_select, 32'h0);
    @(negedge i_clk);
    chk("resume_end", o_data_tight_memory_wait, 32'h0);
    // A DMA write that starts with no core request.
    @(posedge i_clk);
    i_dma_stall <= 1'b1;
    i_dma_address <= 15'h4010;
    i_dma_write <= 1'b1;
    i_dma_lanes <= 4'hf;
    i_dma_write_data <= 32'hdead_beef;
    @(posedge i_clk);
    i_dma_stall <= 1'b0;
    i_dma_write <= 1'b0;
    @(negedge i_clk);
    chk("idle_dma_wait", o_data_tight_memory_wait, 32'h1);
    chk("idle_dma_addr", o_mem_address, 32'h4010);
    chk("idle_dma_sel", o_bank_high_select, 32'h1);
    core_read(15'h4010, 32'hdead_beef);
    $display("test dma done");
    // Sequential ROM fetches, then a nonsequential jump.
    @(posedge i_clk);
    i_instruction_tight_memory_chip_select <= 1'b1;
    i_instruction_tight_memory_address <= 15'h0040;
    @(posedge i_clk);
    i_instruction_tight_memory_sequential <= 1'b1;
    @(negedge i_clk);
    chk("rom_first", o_rom_address, 32'h0040);
    chk("rom_sel", o_rom_select, 32'h1);
    chk("instruction_tight_memory_wait", o_instruction_tight_memory_wait, 32'h1);
    for (int n = 1; n < 4; n++)
    begin
      @(negedge i_clk);
      chk("rom_incr", o_rom_address, 32'h0040 + n);
    end
    @(posedge i_clk);
    i_instruction_tight_memory_sequential <= 1'b0;
    i_instruction_tight_memory_address <= 15'h0123;
    @(posedge i_clk);
    i_instruction_tight_memory_chip_select <= 1'b0;
    @(negedge i_clk);
    chk("rom_jump", o_rom_address, 32'h0123);
    $display("test rom done");
    test_done();
  end
endmodule
`default_nettype wire
